// file: shared/afe_consts.svh
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

// Register addresses (three-bit pointer)
`define REG_STATUS 3'h0
`define REG_ANALOG 3'h1
`define REG_BALANCE 3'h2
`define REG_CURRENT 3'h3
`define REG_REFCRC 3'h4
`define REG_POWER 3'h5

// Reset values
`define RST_STATUS 8'h01
`define RST_ANALOG 8'h10
`define RST_BALANCE 8'h00
`define RST_CURRENT 8'h00
`define RST_REFCRC 8'h81
`define RST_POWER 8'h00

// Writable bits; unnamed positions are never stored
`define MASK_ANALOG 8'h37
`define MASK_BALANCE 8'h3f
`define MASK_CURRENT 8'hfd
`define MASK_REFCRC 8'h81
`define MASK_POWER 8'h5f

// Field positions
`define STAT_POR 0
`define STAT_CRC_ERR 1
`define STAT_OVERCURRENT 2
`define REFCRC_CRC_EN 7
`define PWR_LOW_POWER_BLOCK 6
`define PWR_SLEEP 7

// Serial link
`define DEV_ADDR 7'h08
`define CRC_POLY 8'h07
`define BITS_PER_BYTE 4'h8

`endif

// file: shared/afe_pkg.sv
package afe_pkg;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RX   = 5'b00010,
    S_ACK  = 5'b00100,
    S_TX   = 5'b01000,
    S_MACK = 5'b10000
  } link_state_e;

  typedef struct packed {
    logic [7:0] analog_out_select;
    logic [7:0] balance_switches;
    logic [7:0] current_amp_config;
    logic [7:0] reference_crc_config;
    logic [7:0] power_control;
  } ctrl_regs_s;

endpackage : afe_pkg

// file: hdl/afe_sync2.sv
`timescale 1ns/10ps
module afe_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule : afe_sync2

// file: hdl/afe_crc8.sv
`timescale 1ns/10ps
`include "afe_consts.svh"
module afe_crc8 (
  // Running value and next byte
  input wire logic [7:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [7:0] crc_o
);

  // Bytewise update, most significant bit first
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ data_i;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_o = c;
  end

endmodule : afe_crc8

// file: hdl/afe_control_register_bank.sv
// Overview of operation
// - Reset loads registers 0x00..0x05 with 0x01, 0x10, 0x00, 0x00, 0x81, 0x00.
// - Power-on-reset flag sets at power-up and at every wake from sleep.
// - Each write packet updates the CRC error flag with its CRC outcome.
// - Overcurrent flag follows the synchronised comparator output.
// - Cell select bits 2:0 of register 0x01 pick cell input one to six.
// - Bits 5:4 of register 0x01 pick the cell voltage output source.
// - Bits 5:0 of register 0x02 drive the six balance switches.
// - Bit 0 of register 0x03 picks current amplifier gain four or eight.
// - Bit 2 of register 0x03 picks negative or positive sense input.
// - Bit 3 of register 0x03 picks the current direction that trips.
// - Bits 7:4 of register 0x03 pick one of sixteen trip thresholds.
// - Bit 0 of register 0x04 picks one of two reference levels.
// - Bit 7 of register 0x04 enables the link CRC, on after reset.
// - Bits 4:0 of register 0x05 enable reference, bias, amplifiers, comparator.
// - Bit 6 set in the same write to register 0x05 blocks entry into sleep.
// - Writing one to bit 7 of register 0x05 enters sleep.
// - While asleep the link is silent; reads never show the sleep bit.
// - Sleep turns the regulator output off; a high alert level wakes.
`timescale 1ns/10ps
`include "afe_consts.svh"
module afe_control_register_bank
  import afe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Two-wire serial link, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Analog side
  input wire logic comparator_trip_i,
  input wire logic alert_i,
  output logic regulator_output_o,
  // Control register contents
  output ctrl_regs_s ctrl_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions

  logic [3:0] pins_s;
  logic scl_q;
  logic sda_q;

  afe_sync2 #(.WIDTH(4)) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i({alert_i, comparator_trip_i, sda_i, scl_i}),
    .sync_o(pins_s)
  );

  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire oc_s = pins_s[2];
  wire alert_s = pins_s[3];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_cond = scl_s & scl_q & ~sda_q & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Link state

  link_state_e state;
  link_state_e next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] byte_idx;
  logic rw_read;
  logic [2:0] ptr;
  logic [7:0] wdata_hold;
  logic [7:0] crc_acc;
  logic data_sent;
  logic master_acked;
  logic asleep;
  logic por_flag;
  logic crc_err;
  logic oc_flag;

  wire crc_en = ctrl_o.reference_crc_config[`REFCRC_CRC_EN];
  wire byte_done = (state == S_RX) && (bit_cnt == `BITS_PER_BYTE) && scl_fall;
  wire addr_match = (shreg[7:1] == `DEV_ADDR);
  wire ack_byte = (byte_idx != 2'd0) || addr_match;
  wire tx_last_bit = (state == S_TX) && (bit_cnt == `BITS_PER_BYTE) && scl_fall;
  wire load_tx = scl_fall && (((state == S_ACK) && rw_read) ||
                              ((state == S_MACK) && master_acked));
  wire send_crc = crc_en && data_sent;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: next_state = S_IDLE;
      S_RX: begin
        if (byte_done) next_state = ack_byte ? S_ACK : S_IDLE;
      end
      S_ACK: begin
        if (scl_fall) next_state = rw_read ? S_TX : S_RX;
      end
      S_TX: begin
        if (tx_last_bit) next_state = S_MACK;
      end
      S_MACK: begin
        if (scl_fall) next_state = master_acked ? S_TX : S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    // Sleep silences the link outright; stop beats a start in one sample
    if (asleep) next_state = S_IDLE;
    else if (stop_cond) next_state = S_IDLE;
    else if (start_cond) next_state = S_RX;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and CRC

  logic [7:0] crc_calc;
  wire [7:0] status_byte = {5'h00, oc_flag, crc_err, por_flag};
  // Sleep bit is never stored, so it always reads as zero
  wire [7:0] rd_byte =
    (ptr == `REG_STATUS)  ? status_byte :
    (ptr == `REG_ANALOG)  ? ctrl_o.analog_out_select :
    (ptr == `REG_BALANCE) ? ctrl_o.balance_switches :
    (ptr == `REG_CURRENT) ? ctrl_o.current_amp_config :
    (ptr == `REG_REFCRC)  ? ctrl_o.reference_crc_config :
    (ptr == `REG_POWER)   ? ctrl_o.power_control : 8'h00;
  wire crc_seed_zero = (state == S_RX) && (byte_idx == 2'd0);
  wire [7:0] crc_in = crc_seed_zero ? 8'h00 : crc_acc;
  wire [7:0] crc_data = (state == S_RX) ? shreg : rd_byte;
  wire [7:0] tx_byte = send_crc ? crc_acc : rd_byte;

  afe_crc8 u_crc (
    .crc_i(crc_in),
    .data_i(crc_data),
    .crc_o(crc_calc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire wr_byte = byte_done && !rw_read;
  wire crc_match = (shreg == crc_acc);
  wire wr_check = wr_byte && (((byte_idx == 2'd2) && !crc_en) ||
                              ((byte_idx == 2'd3) && crc_en));
  wire commit_wr = wr_check && (!crc_en || crc_match);
  wire [7:0] commit_data = crc_en ? wdata_hold : shreg;
  wire [7:0] wmask =
    (ptr == `REG_ANALOG)  ? `MASK_ANALOG :
    (ptr == `REG_BALANCE) ? `MASK_BALANCE :
    (ptr == `REG_CURRENT) ? `MASK_CURRENT :
    (ptr == `REG_REFCRC)  ? `MASK_REFCRC :
    (ptr == `REG_POWER)   ? `MASK_POWER : 8'h00;
  wire [7:0] masked_data = commit_data & wmask;
  wire sleep_req = commit_wr && (ptr == `REG_POWER) && commit_data[`PWR_SLEEP] &&
                   !commit_data[`PWR_LOW_POWER_BLOCK];
  wire wake = asleep && alert_s;
  wire next_asleep = sleep_req | (asleep & ~alert_s);
  wire read_status = load_tx && !send_crc && (ptr == `REG_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte engine

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else begin
      state <= next_state;
      if (start_cond || load_tx || (state == S_ACK && scl_fall)) bit_cnt <= 4'h0;
      else if (scl_rise && (state == S_RX || state == S_TX)) bit_cnt <= bit_cnt + 4'h1;
      if (load_tx) shreg <= tx_byte;
      else if (scl_rise && state == S_RX) shreg <= {shreg[6:0], sda_s};
      else if (scl_fall && state == S_TX) shreg <= {shreg[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_idx <= 2'd0;
      rw_read <= 1'b0;
      ptr <= `REG_STATUS;
      wdata_hold <= 8'h00;
      master_acked <= 1'b0;
    end else begin
      if (start_cond) byte_idx <= 2'd0;
      else if (byte_done && byte_idx != 2'd3) byte_idx <= byte_idx + 2'd1;
      if (byte_done && byte_idx == 2'd0) rw_read <= shreg[0];
      if (wr_byte && byte_idx == 2'd1) ptr <= shreg[2:0];
      if (wr_byte && byte_idx == 2'd2) wdata_hold <= shreg;
      if (scl_rise && state == S_MACK) master_acked <= ~sda_s;
    end
  end

  // CRC covers address and data bytes in both directions
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      crc_acc <= 8'h00;
      data_sent <= 1'b0;
    end else begin
      if (byte_done && byte_idx != 2'd3) crc_acc <= crc_calc;
      else if (load_tx && !send_crc) crc_acc <= crc_calc;
      if (start_cond) data_sent <= 1'b0;
      else if (load_tx) data_sent <= ~send_crc;
    end
  end

  // Open drain: only ever pull low
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= !asleep && ((state == S_ACK) || (state == S_TX && !shreg[7]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_o.analog_out_select <= `RST_ANALOG;
      ctrl_o.balance_switches <= `RST_BALANCE;
      ctrl_o.current_amp_config <= `RST_CURRENT;
      ctrl_o.reference_crc_config <= `RST_REFCRC;
      ctrl_o.power_control <= `RST_POWER;
    end else if (commit_wr) begin
      // Fields go straight out to the analog blocks
      if (ptr == `REG_ANALOG) ctrl_o.analog_out_select <= masked_data;
      if (ptr == `REG_BALANCE) ctrl_o.balance_switches <= masked_data;
      if (ptr == `REG_CURRENT) ctrl_o.current_amp_config <= masked_data;
      if (ptr == `REG_REFCRC) ctrl_o.reference_crc_config <= masked_data;
      if (ptr == `REG_POWER) ctrl_o.power_control <= masked_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and sleep

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_flag <= 1'(`RST_STATUS >> `STAT_POR);
      crc_err <= 1'b0;
      oc_flag <= 1'b0;
    end else begin
      // Wake sets, a status read clears; set wins
      if (wake) por_flag <= 1'b1;
      else if (read_status) por_flag <= 1'b0;
      if (wr_check) crc_err <= crc_en && !crc_match;
      oc_flag <= oc_s;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      asleep <= 1'b0;
      regulator_output_o <= 1'b1;
    end else begin
      asleep <= next_asleep;
      regulator_output_o <= ~next_asleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence sleep_write_s;
    commit_wr && (ptr == `REG_POWER) && commit_data[`PWR_SLEEP];
  endsequence

  a_reset_defaults: assert property ($past(reset_i) |->
    (ctrl_o == {8'h10, 8'h00, 8'h00, 8'h81, 8'h00}) && por_flag)
    else $error("register defaults wrong after reset");
  a_status_write_ignored: assert property (
    (commit_wr && ptr == `REG_STATUS && !wake) |=> por_flag == $past(por_flag))
    else $error("status write changed power-on flag");
  a_wake_sets_por: assert property (wake |=> !asleep && por_flag && regulator_output_o)
    else $error("wake did not set power-on flag");
  a_sleep_entry_off: assert property (
    sleep_write_s ##0 !commit_data[`PWR_LOW_POWER_BLOCK] |=> asleep && !regulator_output_o)
    else $error("sleep write did not enter sleep");
  a_sleep_blocked: assert property (
    sleep_write_s ##0 commit_data[`PWR_LOW_POWER_BLOCK] && !asleep |=> !asleep)
    else $error("sleep entered while blocked");
  a_sleep_link_silent: assert property (asleep ##1 asleep |-> !sda_oe_o)
    else $error("link driven while asleep");
  a_sleep_bit_hidden: assert property (ctrl_o.power_control[`PWR_SLEEP] == 1'b0)
    else $error("sleep bit visible in power control");
  a_crc_flag_update: assert property (wr_check |=>
    crc_err == ($past(crc_en) && ($past(shreg) != $past(crc_acc))))
    else $error("crc error flag not updated");
  a_overcurrent_follow: assert property (oc_flag == $past(oc_s))
    else $error("overcurrent flag does not follow comparator");
  a_analog_write_only: assert property (
    !$stable(ctrl_o.analog_out_select) |-> $past(commit_wr) && $past(ptr) == `REG_ANALOG)
    else $error("output select changed without write");
  a_unused_bits_zero: assert property (
    ctrl_o.balance_switches[7:6] == 2'b00 && ctrl_o.analog_out_select[7:6] == 2'b00)
    else $error("unnamed bits stored");

endmodule : afe_control_register_bank

// file: verif/afe_host_model.sv
`timescale 1ns/10ps
module afe_host_model #(
  parameter int HALF = 12
) (
  // Clock
  input wire logic core_clk_i,
  // Bus lines, data as seen on the pulled-up wire
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  logic got;
  logic [7:0] rd_data;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    got = 1'b0;
    rd_data = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_half();
    repeat (HALF) @(negedge core_clk_i);
  endtask : wait_half

  // Data moves two cycles after the clock falls, never with it
  task automatic clock_bit(output logic seen);
    wait_half();
    scl_o = 1'b1;
    wait_half();
    seen = sda_i;
    scl_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask : clock_bit

  task automatic start();
    sda_o = 1'b1;
    wait_half();
    scl_o = 1'b1;
    wait_half();
    sda_o = 1'b0;
    wait_half();
    scl_o = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    wait_half();
    scl_o = 1'b1;
    wait_half();
    sda_o = 1'b1;
    wait_half();
  endtask : stop

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      clock_bit(s);
    end
    sda_o = 1'b1;
    clock_bit(s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic mack);
    logic s;
    logic [7:0] b;
    b = 8'h00;
    sda_o = 1'b1;
    for (int i = 0; i < 8; i++) begin
      clock_bit(s);
      b = {b[6:0], s};
    end
    rd_data = b;
    got = 1'b1;
    sda_o = ~mack;
    clock_bit(s);
    got = 1'b0;
  endtask : recv_byte
endmodule : afe_host_model

// file: verif/test_afe_control_register_bank.sv
`timescale 1ns/10ps
`define CHK(what, got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_afe_control_register_bank
  import afe_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic comparator_trip_i = 1'b0;
  logic alert_i = 1'b0;
  logic host_scl, host_sda, sda_oe, sda_val, regulator;
  // Device pulls low only while enabled and driving a zero
  wire sda_wire = host_sda & ~(sda_oe & ~sda_val);
  ctrl_regs_s ctrl;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic crc_on = 1'b1;
  logic [31:0] seed = 32'h4601627e;
  logic [7:0] exp_q[$];
  logic [7:0] e;
  logic [7:0] last_analog;
  logic [7:0] seen_exp;
  logic a;
  logic [7:0] dflt [6] = '{8'h01, 8'h10, 8'h00, 8'h00, 8'h81, 8'h00};
  logic [7:0] mask [6] = '{8'h00, 8'h37, 8'h3f, 8'hfd, 8'h81, 8'h5f};

  always #10 core_clk_i = ~core_clk_i;

  afe_host_model host (.core_clk_i(core_clk_i), .sda_i(sda_wire), .scl_o(host_scl),
    .sda_o(host_sda));

  afe_control_register_bank dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .scl_i(host_scl), .sda_i(sda_wire), .sda_o(sda_val), .sda_oe_o(sda_oe),
    .comparator_trip_i(comparator_trip_i), .alert_i(alert_i),
    .regulator_output_o(regulator), .ctrl_o(ctrl));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : crc8

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wr(input logic [2:0] ptr, input logic [7:0] d, input logic bad);
    logic a0, a1, a2, a3;
    logic [7:0] c;
    c = crc8(crc8(crc8(8'h00, 8'h10), {5'h00, ptr}), d) ^ {7'h00, bad};
    host.start();
    host.send_byte(8'h10, a0);
    host.send_byte({5'h00, ptr}, a1);
    host.send_byte(d, a2);
    if (crc_on) host.send_byte(c, a3);
    host.stop();
    `CHK("write ack", {a0, a1, a2}, 3'h7)
  endtask : wr

  task automatic rd(input logic [2:0] ptr, input logic [7:0] x);
    logic a0, a1, a2;
    host.start();
    host.send_byte(8'h10, a0);
    host.send_byte({5'h00, ptr}, a1);
    host.start();
    host.send_byte(8'h11, a2);
    exp_q.push_back(x);
    if (crc_on) begin
      exp_q.push_back(crc8(crc8(8'h00, 8'h11), x));
      host.recv_byte(1'b1);
    end
    host.recv_byte(1'b0);
    host.stop();
    `CHK("read ack", {a0, a1, a2}, 3'h7)
  endtask : rd

  task automatic summarize();
    $display("Checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Read results are judged here, oldest expectation first
  always @(posedge host.got) begin
    seen_exp = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    `CHK("read data", host.rd_data, seen_exp)
  end

  // Cycle ceiling well above the roughly 62k cycles of traffic below
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    `CHK("ctrl after reset", ctrl, 40'h1000008100)
    `CHK("regulator after reset", regulator, 1'b1)
    for (int i = 0; i < 6; i++) rd(i[2:0], dflt[i]);
    rd(3'h0, 8'h00);
    $display("Test defaults done");
    for (int n = 0; n < 3; n++) begin
      for (int r = 1; r < 6; r++) begin
        seed = lfsr(seed);
        e = (seed[7:0] & mask[r]) | ((r == 4) ? 8'h80 : 8'h00);
        wr(r[2:0], e, 1'b0);
        if (r == 1) last_analog = e;
        `CHK("ctrl field", ctrl[8*(5-r) +: 8], e)
        rd(r[2:0], e);
      end
    end
    wr(3'h4, 8'h00, 1'b0);
    crc_on = 1'b0;
    wr(3'h2, 8'h2a, 1'b0);
    `CHK("write without crc", ctrl.balance_switches, 8'h2a)
    wr(3'h4, 8'h81, 1'b0);
    crc_on = 1'b1;
    rd(3'h4, 8'h81);
    $display("Test field writes done");
    // Every named bit differs from the stored value, so a leak shows
    e = ~last_analog & 8'h37;
    wr(3'h1, e, 1'b1);
    `CHK("bad crc not stored", ctrl.analog_out_select, last_analog)
    rd(3'h0, 8'h02);
    wr(3'h1, e, 1'b0);
    `CHK("good crc stored", ctrl.analog_out_select, e)
    wr(3'h0, 8'h07, 1'b0);
    rd(3'h0, 8'h00);
    comparator_trip_i = 1'b1;
    rd(3'h0, 8'h04);
    comparator_trip_i = 1'b0;
    rd(3'h0, 8'h00);
    $display("Test status flags done");
    wr(3'h5, 8'h1f, 1'b0);
    `CHK("polling enables", ctrl.power_control, 8'h1f)
    wr(3'h5, 8'hc0, 1'b0);
    `CHK("sleep blocked", regulator, 1'b1)
    rd(3'h5, 8'h40);
    wr(3'h5, 8'h80, 1'b0);
    `CHK("regulator asleep", regulator, 1'b0)
    host.start();
    host.send_byte(8'h10, a);
    host.stop();
    `CHK("no ack asleep", a, 1'b0)
    alert_i = 1'b1;
    for (int i = 0; i < 20 && regulator !== 1'b1; i++) @(negedge core_clk_i);
    `CHK("regulator on wake", regulator, 1'b1)
    alert_i = 1'b0;
    rd(3'h0, 8'h01);
    $display("Test sleep and wake done");
    summarize();
  end
endmodule : test_afe_control_register_bank
